// ### src/smshcr_pkg.sv
// shared constants and carrier types for the mode, supply and hardware control register bank
// assumes a 50 MHz system clock and an lsb-first 16-bit serial frame
package smshcr_pkg;

    // ------------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------------
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned ADDR_LSB   = 0;
    localparam int unsigned ADDR_MSB   = 6;
    localparam int unsigned ACCESS_BIT = 7;
    localparam int unsigned DATA_LSB   = 8;
    localparam int unsigned DATA_MSB   = 15;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
    localparam logic [6:0] ADDR_HW_CTRL0    = 7'h02;

    // ------------------------------------------------------------------
    // operating mode codes
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP  = 2'h1;
    localparam logic [1:0] MODE_STOP   = 2'h2;
    localparam logic [1:0] MODE_SOFT   = 2'h3;

    // ------------------------------------------------------------------
    // register layouts
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] op_mode;
        logic       ext_regulator_enable;
        logic [1:0] rsvd;
        logic       io_overvoltage_reaction;
        logic [1:0] io_reset_threshold;
    } smshcr_mode_supply_t;

    typedef struct packed {
        logic rsvd7;
        logic buck_lag_time;
        logic failure_output_soft_force;
        logic buck_mode_by_wake_pin;
        logic buck_auto_pwm;
        logic rsvd2;
        logic boost_enable;
        logic alt_failure_config;
    } smshcr_hw_ctrl_t;

    localparam smshcr_mode_supply_t MODE_SUPPLY_RESET = 8'h00;
    localparam smshcr_hw_ctrl_t     HW_CTRL0_RESET    = 8'h00;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned LAG_SHORT_NS   = 100000;
    localparam int unsigned LAG_LONG_NS    = 1000000;
    localparam int unsigned LAG_SHORT_CYC  = (LAG_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LAG_LONG_CYC   = (LAG_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LAG_CNT_W      = 20;

    // ------------------------------------------------------------------
    // serial frame carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic       write;
        logic [6:0] addr;
    } smshcr_frame_t;

endpackage : smshcr_pkg

// ### src/smshcr_top.sv
// mode, supply and hardware control register bank behind a 16-bit serial slave port
// assumes spi_clk idles outside frames and spi_cs_n is low for 3+ sys_clk before the first edge
//
// Behaviour
// - power-on or soft reset loads both registers with their reset values
// - restart loads restart values; x bits keep, y bits may change by hardware
// - frame is 16 bits: 7-bit address, access bit, then data byte
// - data bits D0..D7 travel in frame bits 8 to 15
// - frame bit 7 clear reads, set writes one byte
// - hardware-updatable fields are read/write and device-modifiable; reserved reads zero
// - mode field 7:6 selects normal, sleep, stop, or soft reset
// - a written change from stop straight to sleep is refused
// - entering restart rewrites the mode field to normal
// - a write frame returns the previous register content on the output
// - bit 5 switches external regulator; grounded config pin forces it read 1
// - on restart the regulator bit keeps if pin high, sets if pin low
// - bit 2 set makes io overvoltage also request restart or fail-safe
// - bits 1:0 pick one of four io reset thresholds, 00 highest
// - bit 6 sets buck pwm-to-pfm lag: 100 us or 1 ms
// - bit 5 of hardware control forces failure output active
// - restart clears failure force; clearing never hides a present failure
// - in stop, bit 4 lets wake pin choose buck pwm, else pfm
// - bit 3 lets heavy load lift buck to pwm until stop is rewritten
// - bit 1 enables boost, which runs only at low supply
// - bit 0 selects failure output configuration
`timescale 1ns/1ps

module smshcr_top #(
    parameter int unsigned LAG_SHORT = smshcr_pkg::LAG_SHORT_CYC,
    parameter int unsigned LAG_LONG  = smshcr_pkg::LAG_LONG_CYC
) (
    input  wire logic       sys_clk,              // system clock, 50 MHz
    input  wire logic       rst_n,                // async active-low power-on reset
    input  wire logic       spi_clk,              // serial clock from the controller
    input  wire logic       spi_cs_n,             // frame select, active low
    input  wire logic       spi_mosi,             // serial data in, sampled on rising spi_clk
    output logic            spi_miso,             // serial data out, changes on rising spi_clk
    output logic            spi_miso_oe,          // high while the block drives spi_miso
    input  wire logic       output_config_pin,    // low when the config pin is grounded
    input  wire logic       wake_input_pin,       // wake pin level
    input  wire logic       restart_req,          // one-cycle pulse: device enters restart
    input  wire logic       io_overvoltage_flag,  // one-cycle pulse: io overvoltage seen
    input  wire logic       failure_detected,     // level: a defined failure is present
    input  wire logic       buck_heavy_load,      // level: buck needs large current
    input  wire logic       low_supply,           // level: supply below boost threshold
    output logic [1:0]      op_mode,              // current operating mode
    output logic            soft_reset_pulse,     // one-cycle pulse on soft reset command
    output logic            ext_regulator_enable, // external regulator on
    output logic            io_ov_reaction_req,   // one-cycle pulse: restart/fail-safe request
    output logic [1:0]      io_reset_threshold,   // selected io reset threshold
    output logic            buck_pwm,             // 1: buck in pwm, 0: pfm
    output logic            boost_on,             // boost converter running
    output logic            failure_signal_pin,   // failure output, active high
    output logic            alt_failure_config    // failure output configuration select
);

    // ------------------------------------------------------------------
    // state carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [4:0]  cnt;
        logic [14:0] shift;
        logic        miso;
    } smshcr_link_t;

    typedef struct packed {
        smshcr_pkg::smshcr_frame_t word;
        logic                      len_ok;
    } smshcr_capt_t;

    typedef struct packed {
        logic [2:0]                      cs_sync;
        logic [1:0]                      output_config_pin_sync;
        logic [1:0]                      wake_sync;
        smshcr_pkg::smshcr_mode_supply_t msc;
        smshcr_pkg::smshcr_hw_ctrl_t     hwc;
        logic [7:0]                      shadow_msc;
        logic [7:0]                      shadow_hwc;
        logic                            auto_pwm;
        logic                            pwm_req_d;
        logic [smshcr_pkg::LAG_CNT_W-1:0] lag_cnt;
        logic                            miso_oe;
        logic                            soft_pulse;
        logic                            ov_req;
        logic                            pwm;
        logic                            boost;
        logic                            fail_out;
        logic                            ext_on;
    } smshcr_sys_t;

    smshcr_link_t link_ff;
    smshcr_link_t nxt_link;
    smshcr_capt_t capt_ff;
    smshcr_capt_t nxt_capt;
    smshcr_sys_t  sys_ff;
    smshcr_sys_t  nxt_sys;

    // link counters restart with every frame; the select line ends the frame itself
    logic link_rst_n;
    assign link_rst_n = rst_n & ~spi_cs_n;

    // ------------------------------------------------------------------
    // link domain: shift in, drive out
    // ------------------------------------------------------------------
    logic [7:0] rd_sel;

    always_comb begin
        nxt_link = link_ff;
        nxt_capt = capt_ff;
        rd_sel   = 8'h00;
        // shadows are stable while the frame runs, so reading them here is safe
        if (link_ff.shift[6:0] == smshcr_pkg::ADDR_MODE_SUPPLY) begin
            rd_sel = sys_ff.shadow_msc;
        end else if (link_ff.shift[6:0] == smshcr_pkg::ADDR_HW_CTRL0) begin
            rd_sel = sys_ff.shadow_hwc;
        end
        if (link_ff.cnt < 5'd15) begin
            nxt_link.shift[link_ff.cnt[3:0]] = spi_mosi;
        end
        if (link_ff.cnt < 5'd17) begin
            nxt_link.cnt = link_ff.cnt + 5'h01;
        end
        // first byte answers zero, second byte the content before this frame
        if (link_ff.cnt >= 5'd7 && link_ff.cnt < 5'd15) begin
            nxt_link.miso = rd_sel[3'(link_ff.cnt - 5'd7)];
        end else begin
            nxt_link.miso = 1'b0;
        end
        if (link_ff.cnt == 5'd0) begin
            nxt_capt.len_ok = 1'b0;
        end else if (link_ff.cnt == 5'd15) begin
            nxt_capt.word   = {spi_mosi, link_ff.shift};
            nxt_capt.len_ok = 1'b1;
        end else if (link_ff.cnt == 5'd16) begin
            nxt_capt.len_ok = 1'b0;
        end
    end

    always_ff @(posedge spi_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_ff <= '0;
        end else begin
            link_ff <= nxt_link;
        end
    end

    always_ff @(posedge spi_clk or negedge rst_n) begin
        if (!rst_n) begin
            capt_ff <= '0;
        end else begin
            capt_ff <= nxt_capt;
        end
    end

    // ------------------------------------------------------------------
    // system domain: register bank and supply controls
    // ------------------------------------------------------------------
    logic                            cs_rise;
    logic                            cs_fall;
    logic                            output_config_pin_low;
    logic                            in_stop;
    logic                            pwm_req;
    logic [7:0]                      msc_view;
    logic [7:0]                      hwc_view;
    logic [smshcr_pkg::LAG_CNT_W-1:0] lag_len;
    smshcr_pkg::smshcr_frame_t       fr;
    smshcr_pkg::smshcr_mode_supply_t wr_msc;
    smshcr_pkg::smshcr_hw_ctrl_t     wr_hwc;

    always_comb begin
        nxt_sys  = sys_ff;
        cs_rise  = sys_ff.cs_sync[1] & ~sys_ff.cs_sync[2];
        cs_fall  = ~sys_ff.cs_sync[1] & sys_ff.cs_sync[2];
        output_config_pin_low = ~sys_ff.output_config_pin_sync[1];
        fr       = capt_ff.word;
        wr_msc   = fr.data;
        wr_hwc   = fr.data;

        nxt_sys.cs_sync   = {sys_ff.cs_sync[1:0], spi_cs_n};
        nxt_sys.output_config_pin_sync = {sys_ff.output_config_pin_sync[0], output_config_pin};
        nxt_sys.wake_sync = {sys_ff.wake_sync[0], wake_input_pin};
        nxt_sys.miso_oe   = ~sys_ff.cs_sync[1];
        nxt_sys.soft_pulse = 1'b0;

        // read view: reserved bits zero, regulator bit forced by grounded pin
        msc_view    = sys_ff.msc;
        msc_view[4:3] = 2'h0;
        if (output_config_pin_low) begin
            msc_view[5] = 1'b1;
        end
        hwc_view    = sys_ff.hwc;
        hwc_view[7] = 1'b0;
        hwc_view[2] = 1'b0;
        if (cs_fall) begin
            nxt_sys.shadow_msc = msc_view;
            nxt_sys.shadow_hwc = hwc_view;
        end

        if (restart_req) begin
            // restart takes precedence over a frame ending in the same cycle
            nxt_sys.msc.op_mode                  = smshcr_pkg::MODE_NORMAL;
            nxt_sys.msc.io_overvoltage_reaction  = 1'b0;
            if (output_config_pin_low) begin
                nxt_sys.msc.ext_regulator_enable = 1'b1;
            end
            nxt_sys.hwc.failure_output_soft_force = 1'b0;
            nxt_sys.auto_pwm = 1'b0;
        end else if (cs_rise && capt_ff.len_ok && fr.write) begin
            if (fr.addr == smshcr_pkg::ADDR_MODE_SUPPLY) begin
                if (wr_msc.op_mode == smshcr_pkg::MODE_SOFT) begin
                    nxt_sys.msc        = smshcr_pkg::MODE_SUPPLY_RESET;
                    nxt_sys.hwc        = smshcr_pkg::HW_CTRL0_RESET;
                    nxt_sys.auto_pwm   = 1'b0;
                    nxt_sys.soft_pulse = 1'b1;
                end else begin
                    if (!(sys_ff.msc.op_mode == smshcr_pkg::MODE_STOP &&
                          wr_msc.op_mode == smshcr_pkg::MODE_SLEEP)) begin
                        nxt_sys.msc.op_mode = wr_msc.op_mode;
                    end
                    if (wr_msc.op_mode == smshcr_pkg::MODE_STOP) begin
                        nxt_sys.auto_pwm = 1'b0;
                    end
                    nxt_sys.msc.ext_regulator_enable    = wr_msc.ext_regulator_enable;
                    nxt_sys.msc.io_overvoltage_reaction = wr_msc.io_overvoltage_reaction;
                    nxt_sys.msc.io_reset_threshold      = wr_msc.io_reset_threshold;
                end
            end else if (fr.addr == smshcr_pkg::ADDR_HW_CTRL0) begin
                nxt_sys.hwc       = wr_hwc;
                nxt_sys.hwc.rsvd7 = 1'b0;
                nxt_sys.hwc.rsvd2 = 1'b0;
            end
        end

        // heavy-load lift in stop; set wins over a clearing stop command
        in_stop = (sys_ff.msc.op_mode == smshcr_pkg::MODE_STOP);
        if (in_stop && sys_ff.hwc.buck_auto_pwm && buck_heavy_load) begin
            nxt_sys.auto_pwm = 1'b1;
        end else if (!in_stop) begin
            nxt_sys.auto_pwm = 1'b0;
        end

        // buck policy: pwm outside stop; in stop only by wake pin or heavy-load lift
        if (in_stop) begin
            pwm_req = (sys_ff.hwc.buck_mode_by_wake_pin & sys_ff.wake_sync[1])
                    | sys_ff.auto_pwm;
        end else begin
            pwm_req = 1'b1;
        end
        lag_len = sys_ff.hwc.buck_lag_time ? smshcr_pkg::LAG_CNT_W'(LAG_LONG)
                                           : smshcr_pkg::LAG_CNT_W'(LAG_SHORT);
        nxt_sys.pwm_req_d = pwm_req;
        if (pwm_req) begin
            nxt_sys.pwm     = 1'b1;
            nxt_sys.lag_cnt = '0;
        end else if (sys_ff.pwm) begin
            // hold pwm for the lag time before dropping to pfm
            if (sys_ff.lag_cnt + smshcr_pkg::LAG_CNT_W'(1) >= lag_len) begin
                nxt_sys.pwm     = 1'b0;
                nxt_sys.lag_cnt = '0;
            end else begin
                nxt_sys.lag_cnt = sys_ff.lag_cnt + smshcr_pkg::LAG_CNT_W'(1);
            end
        end

        nxt_sys.ov_req   = io_overvoltage_flag & sys_ff.msc.io_overvoltage_reaction;
        nxt_sys.boost    = sys_ff.hwc.boost_enable & low_supply;
        // a present failure keeps the output on whatever the force bit says
        nxt_sys.fail_out = sys_ff.hwc.failure_output_soft_force | failure_detected;
        // a grounded config pin keeps the regulator on whatever the stored bit says
        nxt_sys.ext_on   = sys_ff.msc.ext_regulator_enable | output_config_pin_low;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_ff           <= '0;
            sys_ff.cs_sync   <= 3'h7;
            sys_ff.output_config_pin_sync <= 2'h3;
            sys_ff.msc       <= smshcr_pkg::MODE_SUPPLY_RESET;
            sys_ff.hwc       <= smshcr_pkg::HW_CTRL0_RESET;
            sys_ff.pwm       <= 1'b1;
            sys_ff.pwm_req_d <= 1'b1;
        end else begin
            sys_ff <= nxt_sys;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign spi_miso             = link_ff.miso;
    assign spi_miso_oe          = sys_ff.miso_oe;
    assign op_mode              = sys_ff.msc.op_mode;
    assign soft_reset_pulse     = sys_ff.soft_pulse;
    assign ext_regulator_enable = sys_ff.ext_on;
    assign io_ov_reaction_req   = sys_ff.ov_req;
    assign io_reset_threshold   = sys_ff.msc.io_reset_threshold;
    assign buck_pwm             = sys_ff.pwm;
    assign boost_on             = sys_ff.boost;
    assign failure_signal_pin   = sys_ff.fail_out;
    assign alt_failure_config   = sys_ff.hwc.alt_failure_config;

endmodule // smshcr_top

// ### test/smshcr_properties.sv
// checker for the mode, supply and hardware control register bank
// assumes it is bound onto smshcr_top and sees only its ports
`timescale 1ns/1ps
module smshcr_properties #(
    parameter int unsigned LAG_SHORT = 5,
    parameter int unsigned LAG_LONG  = 20
) (
    input wire logic       sys_clk,              // system clock
    input wire logic       rst_n,                // async reset, active low
    input wire logic       spi_cs_n,             // frame select
    input wire logic       spi_miso_oe,          // serial output enable
    input wire logic       output_config_pin,    // 0 = grounded
    input wire logic       restart_req,          // restart pulse
    input wire logic       io_overvoltage_flag,  // overvoltage event
    input wire logic       failure_detected,     // failure level
    input wire logic       low_supply,           // low supply level
    input wire logic [1:0] op_mode,              // operating mode
    input wire logic       soft_reset_pulse,     // soft reset pulse
    input wire logic       ext_regulator_enable, // regulator on
    input wire logic       io_ov_reaction_req,   // reaction pulse
    input wire logic       buck_pwm,             // buck in pwm
    input wire logic       boost_on,             // boost running
    input wire logic       failure_signal_pin    // failure output
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ov_reaction_a: assert property (io_ov_reaction_req |-> $past(io_overvoltage_flag))
        else $error("overvoltage reaction without an event");
    boost_gate_a: assert property (boost_on |-> $past(low_supply))
        else $error("boost running without low supply");
    fail_follow_a: assert property (failure_detected |=> failure_signal_pin)
        else $error("failure output dropped while failure present");
    restart_mode_a: assert property (restart_req |=> op_mode == 2'h0)
        else $error("mode not normal after restart");
    soft_mode_a: assert property (soft_reset_pulse |-> ##[0:2] op_mode == 2'h0)
        else $error("mode not cleared by soft reset");
    grounded_reg_a: assert property ((!output_config_pin [*4]) ##0 restart_req
        |-> ##[1:3] ext_regulator_enable) else $error("regulator off after restart");
    idle_output_a: assert property (spi_cs_n [*4] |-> !spi_miso_oe)
        else $error("serial output driven outside a frame");
    frame_hold_a: assert property ((!spi_cs_n && !restart_req) [*4] |=> $stable(op_mode))
        else $error("mode changed inside a frame");
    buck_run_a: assert property ((op_mode != 2'h2) [*3] |-> buck_pwm)
        else $error("buck left pwm outside stop");
    soft_pulse_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset pulse longer than one cycle");
endmodule // smshcr_properties

bind smshcr_top smshcr_properties #(.LAG_SHORT(LAG_SHORT), .LAG_LONG(LAG_LONG)) u_smshcr_properties (
    .sys_clk(sys_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
    .output_config_pin(output_config_pin), .restart_req(restart_req),
    .io_overvoltage_flag(io_overvoltage_flag), .failure_detected(failure_detected),
    .low_supply(low_supply), .op_mode(op_mode), .soft_reset_pulse(soft_reset_pulse),
    .ext_regulator_enable(ext_regulator_enable), .io_ov_reaction_req(io_ov_reaction_req),
    .buck_pwm(buck_pwm), .boost_on(boost_on), .failure_signal_pin(failure_signal_pin)
);

// ### test/smshcr_spi_model.sv
// serial controller model: sends lsb-first frames of nbits bits, 12 ns link clock
// assumes the system clock is 20 ns, so gaps are sized in multiples of it
`timescale 1ns/1ps
module smshcr_spi_model (
    output logic      spi_clk,    // stands low outside frames
    output logic      spi_cs_n,   // frame select, active low
    output logic      spi_mosi,   // frame bits, lsb first
    input  wire logic spi_miso,   // register content
    input  wire logic spi_miso_oe // output enable of the block
);
    initial begin
        spi_clk  = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    task automatic xfer(input logic [15:0] frm, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        spi_cs_n = 1'b0;
        #80;
        for (int i = 0; i < nbits; i++) begin
            spi_mosi = frm[i];
            #6 spi_clk = 1'b1;
            #6 spi_clk = 1'b0;
            if (i >= 7 && i <= 14) rd[i-7] = spi_miso_oe ? spi_miso : 1'bx;
        end
        #6 spi_cs_n = 1'b1;
        // a released line must not keep looking valid
        spi_mosi = ~spi_mosi;
        #160;
    endtask
endmodule // smshcr_spi_model

// ### test/tb_top.sv
// self-checking bench for the control register bank
// assumes the serial model answers for the controller
`timescale 1ns/1ps
module tb_top;
    localparam int LAG_S = 5;
    localparam int LAG_L = 20;
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic       output_config_pin = 1'b1;
    logic       wake_input_pin = 1'b0;
    logic       restart_req = 1'b0;
    logic       io_overvoltage_flag = 1'b0;
    logic       failure_detected = 1'b0;
    logic       buck_heavy_load = 1'b0;
    logic       low_supply = 1'b0;
    logic [1:0] op_mode, io_reset_threshold;
    logic       soft_reset_pulse, ext_regulator_enable, io_ov_reaction_req;
    logic       buck_pwm, boost_on, failure_signal_pin, alt_failure_config;
    logic [7:0] rd;
    int         fails = 0;
    int         samples_checked = 0;
    int         cyc = 0;

    always #10 sys_clk = ~sys_clk;

    smshcr_spi_model u_smshcr_spi_model (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

    smshcr_top #(.LAG_SHORT(LAG_S), .LAG_LONG(LAG_L)) u_smshcr_top (
        .sys_clk(sys_clk), .rst_n(rst_n), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .output_config_pin(output_config_pin), .wake_input_pin(wake_input_pin),
        .restart_req(restart_req), .io_overvoltage_flag(io_overvoltage_flag),
        .failure_detected(failure_detected), .buck_heavy_load(buck_heavy_load),
        .low_supply(low_supply), .op_mode(op_mode), .soft_reset_pulse(soft_reset_pulse),
        .ext_regulator_enable(ext_regulator_enable), .io_ov_reaction_req(io_ov_reaction_req),
        .io_reset_threshold(io_reset_threshold), .buck_pwm(buck_pwm), .boost_on(boost_on),
        .failure_signal_pin(failure_signal_pin), .alt_failure_config(alt_failure_config));

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // lands one step after the edge so flop outputs have settled
    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [7:0] prev);
        u_smshcr_spi_model.xfer({d, 1'b1, a}, 16, rd);
        check("write echo", prev, rd);
    endtask

    task automatic rr(input logic [6:0] a, input logic [7:0] exp);
        u_smshcr_spi_model.xfer({8'h00, 1'b0, a}, 16, rd);
        check("read data", exp, rd);
    endtask

    // hang guard: the whole sequence needs well under 3000 cycles
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            test_done();
        end
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        ticks(3);
        rr(7'h01, 8'h00);
        rr(7'h02, 8'h00);
        $display("reset values done");
        wr(7'h01, 8'hbf, 8'h00);
        rr(7'h01, 8'ha7);
        check("op_mode", 8'h02, {6'h00, op_mode});
        check("threshold", 8'h03, {6'h00, io_reset_threshold});
        check("regulator", 8'h01, {7'h00, ext_regulator_enable});
        @(posedge sys_clk) io_overvoltage_flag <= 1'b1;
        @(posedge sys_clk) io_overvoltage_flag <= 1'b0;
        #1 check("ov reaction", 8'h01, {7'h00, io_ov_reaction_req});
        wr(7'h01, 8'h40, 8'ha7);
        @(posedge sys_clk) io_overvoltage_flag <= 1'b1;
        @(posedge sys_clk) io_overvoltage_flag <= 1'b0;
        #1 check("ov no reaction", 8'h00, {7'h00, io_ov_reaction_req});
        rr(7'h01, 8'h80);
        $display("mode and supply done");
        wr(7'h02, 8'h50, 8'h00);
        @(posedge sys_clk) wake_input_pin <= 1'b1;
        ticks(6);
        check("buck by wake", 8'h01, {7'h00, buck_pwm});
        @(posedge sys_clk) wake_input_pin <= 1'b0;
        ticks(LAG_S + 5);
        check("buck long lag", 8'h01, {7'h00, buck_pwm});
        ticks(LAG_L);
        check("buck pfm", 8'h00, {7'h00, buck_pwm});
        wr(7'h02, 8'h08, 8'h50);
        @(posedge sys_clk) buck_heavy_load <= 1'b1;
        ticks(3);
        @(posedge sys_clk) buck_heavy_load <= 1'b0;
        ticks(LAG_L + 5);
        check("buck auto pwm", 8'h01, {7'h00, buck_pwm});
        wr(7'h01, 8'h80, 8'h80);
        ticks(LAG_S + 5);
        check("buck back pfm", 8'h00, {7'h00, buck_pwm});
        $display("buck policy done");
        wr(7'h02, 8'hff, 8'h08);
        rr(7'h02, 8'h7b);
        @(posedge sys_clk) low_supply <= 1'b1;
        ticks(3);
        check("boost", 8'h01, {7'h00, boost_on});
        check("fail forced", 8'h01, {7'h00, failure_signal_pin});
        check("fail config", 8'h01, {7'h00, alt_failure_config});
        $display("hardware control done");
        @(posedge sys_clk) failure_detected <= 1'b1;
        output_config_pin <= 1'b0;
        ticks(4);
        @(posedge sys_clk) restart_req <= 1'b1;
        @(posedge sys_clk) restart_req <= 1'b0;
        ticks(3);
        rr(7'h01, 8'h20);
        rr(7'h02, 8'h5b);
        check("fail held", 8'h01, {7'h00, failure_signal_pin});
        @(posedge sys_clk) failure_detected <= 1'b0;
        ticks(3);
        check("fail released", 8'h00, {7'h00, failure_signal_pin});
        $display("restart done");
        u_smshcr_spi_model.xfer({8'h00, 1'b1, 7'h02}, 15, rd);
        rr(7'h02, 8'h5b);
        rr(7'h05, 8'h00);
        wr(7'h01, 8'h40, 8'h20);
        check("op_mode", 8'h01, {6'h00, op_mode});
        wr(7'h01, 8'hc0, 8'h60);
        rr(7'h01, 8'h20);
        rr(7'h02, 8'h00);
        check("op_mode", 8'h00, {6'h00, op_mode});
        $display("refusals and soft reset done");
        test_done();
    end
endmodule // tb_top
